// ==== lhca_core.sv ====
// limit, heater current and loop-break alarm block with its parameter words
// assumes samples from acquisition logic on core_clk, word-addressed parameter port
`timescale 1ns/100ps
`default_nettype none
`include "lhca_map.svh"

module lhca_core
  import lhca_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // parameter word port
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // measurement samples
  input wire logic sample_valid,
  input wire logic signed [15:0] monitored_value,
  input wire logic signed [15:0] heater_current,
  input wire logic signed [15:0] relay_off_current,
  input wire logic controller_output_on,
  // configuration from other blocks
  input wire logic [1:0] heater_alarm_mode,
  input wire logic limit_latch_mode,
  input wire logic limit_latch_clear,
  input wire logic controller_is_pid,
  // alarm outputs
  output logic limit_alarm,
  output logic heater_alarm,
  output logic relay_short_alarm,
  output logic loop_break_active
);

  // settings
  logic signed [15:0] lower_limit_threshold;
  logic signed [15:0] upper_limit_threshold;
  logic signed [15:0] limit_hysteresis;
  logic signed [15:0] heater_current_limit;
  logic loop_break_enable;
  // readings and status
  logic signed [15:0] heater_current_reading;
  logic signed [15:0] relay_off_current_reading;
  logic [1:0] heater_alarm_status;
  lhca_lim_status_e limit_status_word;
  logic limit_latched;
  logic [1:0] side_alarm;
  logic [1:0] lim_settled;
  logic sample_d;
  logic signed [15:0] wdata_value;
  logic signed [15:0] wdata_hyst;
  logic signed [15:0] limit_sel [2];
  logic next_hc_alarm;
  logic next_short;

  // out-of-range writes are clamped rather than refused, so the word always holds a legal value
  always_comb begin
    if ($signed(reg_wdata) < $signed(`LHCA_VALUE_MIN)) begin
      wdata_value = `LHCA_VALUE_MIN;
    end else if ($signed(reg_wdata) > $signed(`LHCA_VALUE_MAX)) begin
      wdata_value = `LHCA_VALUE_MAX;
    end else begin
      wdata_value = reg_wdata;
    end
    if ($signed(reg_wdata) < $signed(`LHCA_HYST_MIN)) begin
      wdata_hyst = `LHCA_HYST_MIN;
    end else if ($signed(reg_wdata) > $signed(`LHCA_VALUE_MAX)) begin
      wdata_hyst = `LHCA_VALUE_MAX;
    end else begin
      wdata_hyst = reg_wdata;
    end
  end

  // writable settings; read-only addresses fall through untouched
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lower_limit_threshold <= `LHCA_RST_LOWER_LIMIT;
      upper_limit_threshold <= `LHCA_RST_UPPER_LIMIT;
      limit_hysteresis <= `LHCA_RST_HYSTERESIS;
      heater_current_limit <= `LHCA_RST_HEATER_LIMIT;
      loop_break_enable <= `LHCA_RST_LOOP_BREAK;
    end else if (reg_wr) begin
      case (reg_addr)
        `LHCA_ADDR_LOWER_LIMIT: begin
          lower_limit_threshold <= wdata_value;
        end
        `LHCA_ADDR_UPPER_LIMIT: begin
          upper_limit_threshold <= wdata_value;
        end
        `LHCA_ADDR_LIMIT_HYSTERESIS: begin
          limit_hysteresis <= wdata_hyst;
        end
        `LHCA_ADDR_HEATER_CURRENT_LIMIT: begin
          heater_current_limit <= wdata_value;
        end
        `LHCA_ADDR_LOOP_BREAK_ENABLE: begin
          loop_break_enable <= reg_wdata[`LHCA_LOOP_BREAK_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // lower and upper comparators share the one hysteresis word
  assign limit_sel[0] = lower_limit_threshold;
  assign limit_sel[1] = upper_limit_threshold;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_side
      lhca_hyst #(
        .IS_UPPER(gi == 1)
      ) u_cmp (
        .core_clk(core_clk),
        .rst(rst),
        .update(sample_valid),
        .value(monitored_value),
        .limit(limit_sel[gi]),
        .hyst(limit_hysteresis),
        .alarm(side_alarm[gi])
      );
    end
  endgenerate

  // comparator results land on the sample edge; status follows one edge later
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sample_d <= 1'b0;
    end else begin
      sample_d <= sample_valid;
    end
  end

  assign lim_settled = side_alarm;

  // latch: set wins over a clear arriving in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      limit_latched <= 1'b0;
    end else if (sample_d && limit_latch_mode && (|lim_settled)) begin
      limit_latched <= 1'b1;
    end else if (limit_latch_clear || !limit_latch_mode) begin
      limit_latched <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      limit_status_word <= LHCA_LIM_NONE;
      limit_alarm <= 1'b0;
    end else if (sample_d) begin
      // a latched alarm must not drop for a cycle once the value returns
      limit_alarm <= (|lim_settled) || (limit_latched && !limit_latch_clear);
      if (|lim_settled) begin
        limit_status_word <= LHCA_LIM_EXCEEDED;
      end else if (limit_latched && !limit_latch_clear) begin
        limit_status_word <= LHCA_LIM_LATCHED;
      end else begin
        limit_status_word <= LHCA_LIM_NONE;
      end
    end else if (limit_latch_clear && limit_status_word == LHCA_LIM_LATCHED) begin
      limit_status_word <= LHCA_LIM_NONE;
      limit_alarm <= 1'b0;
    end else if (limit_latched) begin
      limit_alarm <= 1'b1;
    end
  end

  // heater checks, evaluated on the raw sample so they share the sample edge
  always_comb begin
    case (heater_alarm_mode)
      LHCA_HC_OVERLOAD: begin
        next_hc_alarm = heater_current > heater_current_limit;
      end
      LHCA_HC_OPEN: begin
        next_hc_alarm = heater_current < heater_current_limit;
      end
      default: begin
        next_hc_alarm = 1'b0;
      end
    endcase
    // short check runs in every heater mode, independent of the overload test
    next_short = !controller_output_on &&
      (relay_off_current >= $signed(`LHCA_SHORT_MIN_CURRENT));
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      heater_current_reading <= 16'h0000;
      relay_off_current_reading <= 16'h0000;
      heater_alarm_status <= 2'h0;
      heater_alarm <= 1'b0;
      relay_short_alarm <= 1'b0;
    end else if (sample_valid) begin
      heater_current_reading <= heater_current;
      relay_off_current_reading <= relay_off_current;
      heater_alarm_status[`LHCA_HSTAT_ALARM_BIT] <= next_hc_alarm;
      heater_alarm_status[`LHCA_HSTAT_SHORT_BIT] <= next_short;
      heater_alarm <= next_hc_alarm;
      relay_short_alarm <= next_short;
    end
  end

  // loop-break supervision only means something for a PID controller
  always_ff @(posedge core_clk) begin
    if (rst) begin
      loop_break_active <= 1'b0;
    end else begin
      loop_break_active <= loop_break_enable && controller_is_pid;
    end
  end

  // read port; unmapped words read as zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `LHCA_ADDR_HEATER_CURRENT_LIMIT: reg_rdata <= heater_current_limit;
          `LHCA_ADDR_HEATER_ALARM_STATUS: reg_rdata <= {14'h0000, heater_alarm_status};
          `LHCA_ADDR_HEATER_CURRENT_READ: reg_rdata <= heater_current_reading;
          `LHCA_ADDR_RELAY_OFF_CURRENT: reg_rdata <= relay_off_current_reading;
          `LHCA_ADDR_LOWER_LIMIT: reg_rdata <= lower_limit_threshold;
          `LHCA_ADDR_UPPER_LIMIT: reg_rdata <= upper_limit_threshold;
          `LHCA_ADDR_LIMIT_HYSTERESIS: reg_rdata <= limit_hysteresis;
          `LHCA_ADDR_LIMIT_STATUS_WORD: reg_rdata <= {14'h0000, limit_status_word};
          `LHCA_ADDR_LOOP_BREAK_ENABLE: reg_rdata <= {15'h0000, loop_break_enable};
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ==== lhca_hyst.sv ====
// one limit comparator with switching difference
// assumes samples and settings on the same clock, update as one-cycle strobe
`timescale 1ns/100ps
`default_nettype none

module lhca_hyst
  import lhca_pkg::*;
#(
  parameter bit IS_UPPER = 1'b0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // sample and settings
  input wire logic update,
  input wire logic signed [15:0] value,
  input wire logic signed [15:0] limit,
  input wire logic signed [15:0] hyst,
  // result
  output logic alarm
);

  // widened so limit plus or minus hysteresis cannot wrap
  logic signed [17:0] val_w;
  logic signed [17:0] release_lvl;
  logic trip;
  logic release_ok;

  assign val_w = {{2{value[15]}}, value};

  always_comb begin
    if (IS_UPPER) begin
      release_lvl = {{2{limit[15]}}, limit} - {{2{hyst[15]}}, hyst};
      trip = val_w > {{2{limit[15]}}, limit};
      release_ok = val_w <= release_lvl;
    end else begin
      release_lvl = {{2{limit[15]}}, limit} + {{2{hyst[15]}}, hyst};
      trip = val_w < {{2{limit[15]}}, limit};
      release_ok = val_w >= release_lvl;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      alarm <= 1'b0;
    end else if (update) begin
      if (trip) begin
        alarm <= 1'b1;
      end else if (release_ok) begin
        alarm <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ==== lhca_map.svh ====
// offsets, field positions, reset values and limits of the alarm block
// assumes word addresses as presented on the parameter port
`ifndef LHCA_MAP_SVH
`define LHCA_MAP_SVH

`define LHCA_ADDR_HEATER_CURRENT_LIMIT  16'h0258
`define LHCA_ADDR_HEATER_ALARM_STATUS   16'h0280
`define LHCA_ADDR_HEATER_CURRENT_READ   16'h0281
`define LHCA_ADDR_RELAY_OFF_CURRENT     16'h0282
`define LHCA_ADDR_LOWER_LIMIT           16'h028A
`define LHCA_ADDR_UPPER_LIMIT           16'h028B
`define LHCA_ADDR_LIMIT_HYSTERESIS      16'h028C
`define LHCA_ADDR_LIMIT_STATUS_WORD     16'h02B2
`define LHCA_ADDR_LOOP_BREAK_ENABLE     16'h04EA

`define LHCA_VALUE_MIN                  16'hF831
`define LHCA_VALUE_MAX                  16'h270F
`define LHCA_HYST_MIN                   16'h0000

`define LHCA_RST_LOWER_LIMIT            16'hF831
`define LHCA_RST_UPPER_LIMIT            16'h270F
`define LHCA_RST_HYSTERESIS             16'h0001
`define LHCA_RST_HEATER_LIMIT           16'h0000
`define LHCA_RST_LOOP_BREAK             1'b0

`define LHCA_SHORT_MIN_CURRENT          16'h0001

`define LHCA_HSTAT_ALARM_BIT            0
`define LHCA_HSTAT_SHORT_BIT            1
`define LHCA_LOOP_BREAK_BIT             0

`endif

// ==== lhca_master.sv ====
// bus master model on the parameter word port
// assumes a one-cycle read answer, inputs moved at falling edges
`timescale 1ns/100ps
`default_nettype none
module lhca_master (
  // clock
  input wire logic core_clk,
  // parameter port
  output logic [15:0] reg_addr,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_addr = 16'h0000;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd = 1'b0;
  end
  // released lines show the inverse so a stale value never passes
  task wr(input logic [15:0] a, d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rvalid ? reg_rdata : 16'hXXXX;
  endtask
endmodule
`default_nettype wire

// ==== lhca_pkg.sv ====
// types shared by the alarm block files
// assumes lhca_map.svh for the numeric layout
package lhca_pkg;

  typedef logic signed [15:0] lhca_value_t;

  typedef enum logic [1:0] {
    LHCA_LIM_NONE     = 2'b00,
    LHCA_LIM_LATCHED  = 2'b01,
    LHCA_LIM_EXCEEDED = 2'b10
  } lhca_lim_status_e;

  typedef enum logic [1:0] {
    LHCA_HC_OFF      = 2'b00,
    LHCA_HC_OVERLOAD = 2'b01,
    LHCA_HC_OPEN     = 2'b10
  } lhca_hc_mode_e;

endpackage

// ==== lhca_props.sv ====
// port checker for the alarm block
// assumes it is bound onto lhca_core
`timescale 1ns/100ps
`default_nettype none
module lhca_props (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // parameter port
  input wire logic reg_rd,
  input wire logic reg_rvalid,
  // samples and config
  input wire logic sample_valid,
  input wire logic signed [15:0] monitored_value,
  input wire logic signed [15:0] relay_off_current,
  input wire logic controller_output_on,
  input wire logic [1:0] heater_alarm_mode,
  input wire logic controller_is_pid,
  // alarms
  input wire logic limit_alarm,
  input wire logic heater_alarm,
  input wire logic relay_short_alarm,
  input wire logic loop_break_active
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // limits clamp to the value range, so these always trip
  sequence s_low;
    sample_valid && monitored_value < -16'sd1999;
  endsequence
  sequence s_high;
    sample_valid && monitored_value > 16'sd9999;
  endsequence
  property p_rd;
    reg_rd |=> reg_rvalid;
  endproperty
  property p_rv;
    reg_rvalid |-> $past(reg_rd);
  endproperty
  property p_low;
    s_low |-> ##2 limit_alarm;
  endproperty
  property p_high;
    s_high |-> ##2 limit_alarm;
  endproperty
  property p_short;
    sample_valid && !controller_output_on && relay_off_current > 0 |=> relay_short_alarm;
  endproperty
  property p_on;
    sample_valid && controller_output_on |=> !relay_short_alarm;
  endproperty
  property p_hoff;
    sample_valid && heater_alarm_mode inside {2'h0, 2'h3} |=> !heater_alarm;
  endproperty
  property p_hold;
    !sample_valid |=> $stable(heater_alarm) && $stable(relay_short_alarm);
  endproperty
  property p_pid;
    !controller_is_pid |=> !loop_break_active;
  endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  a_rv: assert property (p_rv) else $error("answer without read");
  a_low: assert property (p_low) else $error("lower trip missed");
  a_high: assert property (p_high) else $error("upper trip missed");
  a_short: assert property (p_short) else $error("short missed");
  a_on: assert property (p_on) else $error("short with output on");
  a_hoff: assert property (p_hoff) else $error("heater alarm when off");
  a_hold: assert property (p_hold) else $error("alarm moved");
  a_pid: assert property (p_pid) else $error("loop break without pid");
endmodule

bind lhca_core lhca_props u_props (.core_clk(core_clk), .rst(rst), .reg_rd(reg_rd),
  .reg_rvalid(reg_rvalid), .sample_valid(sample_valid), .monitored_value(monitored_value),
  .relay_off_current(relay_off_current), .controller_output_on(controller_output_on),
  .heater_alarm_mode(heater_alarm_mode), .controller_is_pid(controller_is_pid),
  .limit_alarm(limit_alarm), .heater_alarm(heater_alarm),
  .relay_short_alarm(relay_short_alarm), .loop_break_active(loop_break_active));
`default_nettype wire

// ==== limit_heater_current_alarm_tb.sv ====
// self-checking bench for the alarm block
// assumes lhca_master drives the parameter port
`timescale 1ns/100ps
`default_nettype none
module limit_heater_current_alarm_tb;
  logic core_clk, rst, rd, wr, rv, sv, on, lm, lc, pid, la, ha, rs, lb;
  logic [15:0] ad, wd, rdat, q;
  logic signed [15:0] mv, hc, rc;
  logic [1:0] hm;
  int n_mismatch, n_compared;
  logic [15:0] ra[10] = '{16'h0258, 16'h0280, 16'h0281, 16'h0282, 16'h028A,
    16'h028B, 16'h028C, 16'h02B2, 16'h04EA, 16'h0123};
  logic [15:0] r0[10] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'hF831, 16'h270F, 16'h1,
    16'h0, 16'h0, 16'h0};
  logic signed [15:0] lv[8] = '{100, 99, 105, 110, 200, 201, 191, 190};
  logic [15:0] ls[8] = '{16'h0, 16'h2, 16'h2, 16'h0, 16'h0, 16'h2, 16'h2, 16'h0};
  lhca_core uut (.core_clk(core_clk), .rst(rst), .reg_addr(ad), .reg_wr(wr),
    .reg_wdata(wd), .reg_rd(rd), .reg_rdata(rdat), .reg_rvalid(rv),
    .sample_valid(sv), .monitored_value(mv), .heater_current(hc),
    .relay_off_current(rc), .controller_output_on(on), .heater_alarm_mode(hm),
    .limit_latch_mode(lm), .limit_latch_clear(lc), .controller_is_pid(pid),
    .limit_alarm(la), .heater_alarm(ha), .relay_short_alarm(rs),
    .loop_break_active(lb));
  lhca_master m (.core_clk(core_clk), .reg_addr(ad), .reg_wr(wr), .reg_wdata(wd),
    .reg_rd(rd), .reg_rdata(rdat), .reg_rvalid(rv));
  task chk(input logic [15:0] s, e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("FAIL %0t seen %h want %h", $time, s, e);
    end
  endtask
  task rchk(input logic [15:0] a, e);
    m.rd(a, q);
    chk(q, e);
  endtask
  // status settles one edge after the taking edge
  task smp(input logic signed [15:0] v, c, r);
    @(negedge core_clk);
    mv = v;
    hc = c;
    rc = r;
    sv = 1'b1;
    @(negedge core_clk);
    sv = 1'b0;
    @(negedge core_clk);
  endtask
  task ht(input logic [1:0] md, input logic o, input logic signed [15:0] c, r,
    input logic [15:0] e);
    hm = md;
    on = o;
    smp(16'sd150, c, r);
    rchk(16'h0280, e);
    chk({14'h0, rs, ha}, e);
    rchk(16'h0281, c);
    rchk(16'h0282, r);
  endtask
  task close_out;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    repeat (3000) @(posedge core_clk);
    n_mismatch++;
    close_out;
  end
  initial begin
    rst = 1'b1;
    sv = 1'b0;
    mv = 16'sh0;
    hc = 16'sh0;
    rc = 16'sh0;
    on = 1'b1;
    hm = 2'h0;
    lm = 1'b0;
    lc = 1'b0;
    pid = 1'b0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    foreach (ra[i]) rchk(ra[i], r0[i]);
    m.wr(16'h028A, 16'h8000);
    rchk(16'h028A, 16'hF831);
    m.wr(16'h028C, 16'hFFFF);
    rchk(16'h028C, 16'h0000);
    m.wr(16'h0281, 16'h1234);
    rchk(16'h0281, 16'h0000);
    m.wr(16'h04EA, 16'hFFFF);
    rchk(16'h04EA, 16'h0001);
    pid = 1'b1;
    repeat (2) @(negedge core_clk);
    chk({15'h0, lb}, 16'h1);
    pid = 1'b0;
    repeat (2) @(negedge core_clk);
    chk({15'h0, lb}, 16'h0);
    $display("test regs done");
    m.wr(16'h028A, 16'h0064);
    m.wr(16'h028B, 16'h00C8);
    m.wr(16'h028C, 16'h000A);
    foreach (lv[i]) begin
      smp(lv[i], 16'sh0, 16'sh0);
      rchk(16'h02B2, ls[i]);
      chk({15'h0, la}, {15'h0, ls[i][1]});
    end
    smp(16'sd10000, 16'sh0, 16'sh0);
    rchk(16'h02B2, 16'h0002);
    smp(-16'sd2000, 16'sh0, 16'sh0);
    rchk(16'h02B2, 16'h0002);
    lm = 1'b1;
    smp(16'sd99, 16'sh0, 16'sh0);
    smp(16'sd150, 16'sh0, 16'sh0);
    rchk(16'h02B2, 16'h0001);
    chk({15'h0, la}, 16'h1);
    lc = 1'b1;
    @(negedge core_clk);
    lc = 1'b0;
    rchk(16'h02B2, 16'h0000);
    chk({15'h0, la}, 16'h0);
    lm = 1'b0;
    $display("test limits done");
    m.wr(16'h0258, 16'h0032);
    ht(2'h1, 1'b1, 16'sd51, 16'sd0, 16'h1);
    ht(2'h1, 1'b1, 16'sd50, 16'sd0, 16'h0);
    ht(2'h2, 1'b1, 16'sd49, 16'sd0, 16'h1);
    ht(2'h2, 1'b1, 16'sd51, 16'sd0, 16'h0);
    ht(2'h0, 1'b1, 16'sd99, 16'sd7, 16'h0);
    ht(2'h3, 1'b1, 16'sd0, 16'sd0, 16'h0);
    ht(2'h1, 1'b0, 16'sd51, 16'sd5, 16'h3);
    ht(2'h0, 1'b0, -16'sd1999, 16'sd1, 16'h2);
    ht(2'h1, 1'b0, 16'sd51, 16'sd0, 16'h1);
    $display("test heater done");
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    rchk(16'h028A, 16'hF831);
    rchk(16'h0280, 16'h0000);
    chk({12'h0, la, ha, rs, lb}, 16'h0);
    $display("test reset done");
    close_out;
  end
endmodule
`default_nettype wire
